//--- design/mou_core.sv
`timescale 1ns/1ps

// Overview of operation
// - Loads may pass older stores elsewhere
// - Same-address load sees older store value
// - Pending store forwards to own loads
// - Pending stores hidden from other processors
// - No global order across processors' stores
// - Causally related stores seen in order
// - Stores to one location totally ordered
// - Locked operations totally ordered system-wide
// - Loads complete in program order
// - Store never visible before older load
// - Stores drain to memory in order
// - Swap is indivisible load then store

module mou_core #(
  parameter int DEPTH = mou_pkg::SB_DEPTH
) (
  input  wire logic                        mclk,
  input  wire logic                        reset,
  // Pipeline side
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic [1:0]                  req_op,
  input  wire logic [mou_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [mou_pkg::DATA_W-1:0]  req_wdata,
  output logic                             rsp_valid,
  output logic [mou_pkg::DATA_W-1:0]       rsp_rdata,
  // Coherent memory side
  output logic                             mem_req,
  output logic                             mem_we,
  output logic                             mem_lock,
  output logic [mou_pkg::ADDR_W-1:0]       mem_addr,
  output logic [mou_pkg::DATA_W-1:0]       mem_wdata,
  input  wire logic                        mem_gnt,
  input  wire logic                        mem_rvalid,
  input  wire logic [mou_pkg::DATA_W-1:0]  mem_rdata,
  output logic                             sb_empty
);

  localparam int AW = mou_pkg::ADDR_W;
  localparam int DW = mou_pkg::DATA_W;
  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH)
      $error("mou_core: DEPTH must be a power of two, at least 2");
  end

  typedef enum logic [2:0] {
    MOU_IDLE,
    MOU_LD_WAIT,
    MOU_LK_DRAIN,
    MOU_LK_RD,
    MOU_LK_RWAIT,
    MOU_LK_WR
  } mou_state_t;

  // ==========================================================
  // State
  // ==========================================================
  mou_state_t          state_q, state_d;
  logic [DEPTH-1:0]    sb_valid_q;
  logic [AW-1:0]       sb_addr_q [DEPTH];
  logic [DW-1:0]       sb_data_q [DEPTH];
  logic [PW-1:0]       head_q;
  logic [PW-1:0]       tail_q;
  logic [AW-1:0]       op_addr_q;
  logic [DW-1:0]       op_wdata_q;
  logic                rsp_valid_q;
  logic [DW-1:0]       rsp_rdata_q;
  logic                drain_busy_q;

  // ==========================================================
  // Forwarding lookup
  // ==========================================================
  logic [DEPTH*AW-1:0] addr_flat;
  logic [DEPTH*DW-1:0] data_flat;
  logic                fwd_hit;
  logic [DW-1:0]       fwd_data;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      addr_flat[i*AW +: AW] = sb_addr_q[i];
      data_flat[i*DW +: DW] = sb_data_q[i];
    end
  end

  // Every valid entry is older than the incoming load
  mou_sb_match #(
    .DEPTH     (DEPTH),
    .AW        (AW),
    .DW        (DW),
    .PW        (PW)
  ) u_match (
    .valid     (sb_valid_q),
    .addr_flat (addr_flat),
    .data_flat (data_flat),
    .head      (head_q),
    .look_addr (req_addr),
    .hit       (fwd_hit),
    .hit_data  (fwd_data)
  );

  // ==========================================================
  // Decode
  // ==========================================================
  wire sb_full    = &sb_valid_q;
  wire sb_none    = ~|sb_valid_q;
  wire is_load    = req_op == mou_pkg::MOU_OP_LOAD;
  wire is_store   = req_op == mou_pkg::MOU_OP_STORE;
  wire is_swap    = req_op == mou_pkg::MOU_OP_SWAP;
  wire idle       = state_q == MOU_IDLE;
  // Load owns the memory port only when the drainer is not mid-grant
  wire load_mem   = idle && req_valid && is_load && !fwd_hit &&
                    !drain_busy_q;
  wire store_acc  = idle && req_valid && is_store && !sb_full;
  wire load_fwd   = idle && req_valid && is_load && fwd_hit;
  wire swap_acc   = idle && req_valid && is_swap;
  // Drain only when no load or lock owns the port
  wire drain_ok   = !sb_none && (idle || state_q == MOU_LK_DRAIN) &&
                    !load_mem;
  wire drain_done = drain_ok && mem_gnt;
  wire lk_rd_gnt  = state_q == MOU_LK_RD && mem_gnt;
  wire lk_wr_gnt  = state_q == MOU_LK_WR && mem_gnt;

  // One request at a time; loads retire in order
  assign req_ready = store_acc || load_fwd || swap_acc ||
                     (load_mem && mem_gnt);

  // ==========================================================
  // Memory port mux
  // ==========================================================
  // Only drained entries reach memory; buffer is private
  always_comb begin
    mem_req   = 1'b0;
    mem_we    = 1'b0;
    mem_lock  = 1'b0;
    mem_addr  = '0;
    mem_wdata = '0;
    if (state_q == MOU_LK_RD) begin
      mem_req  = 1'b1;
      mem_lock = 1'b1;
      mem_addr = op_addr_q;
    end else if (state_q == MOU_LK_WR) begin
      mem_req   = 1'b1;
      mem_we    = 1'b1;
      mem_lock  = 1'b1;
      mem_addr  = op_addr_q;
      mem_wdata = op_wdata_q;
    end else if (load_mem) begin
      // Load may bypass unmatched buffered stores
      mem_req  = 1'b1;
      mem_addr = req_addr;
    end else if (drain_ok) begin
      // Oldest entry first
      mem_req   = 1'b1;
      mem_we    = 1'b1;
      mem_addr  = sb_addr_q[head_q];
      mem_wdata = sb_data_q[head_q];
    end
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  always_comb begin
    state_d = state_q;
    case (state_q)
      MOU_IDLE: begin
        if (swap_acc) begin
          state_d = MOU_LK_DRAIN;
        end else if (load_mem && mem_gnt) begin
          state_d = MOU_LD_WAIT;
        end
      end
      MOU_LD_WAIT: begin
        if (mem_rvalid) begin
          state_d = MOU_IDLE;
        end
      end
      MOU_LK_DRAIN: begin
        // Older stores drain before the lock begins
        if (sb_none) begin
          state_d = MOU_LK_RD;
        end
      end
      MOU_LK_RD: begin
        if (mem_gnt) begin
          state_d = MOU_LK_RWAIT;
        end
      end
      MOU_LK_RWAIT: begin
        // Store follows only after the load returned
        if (mem_rvalid) begin
          state_d = MOU_LK_WR;
        end
      end
      MOU_LK_WR: begin
        if (mem_gnt) begin
          state_d = MOU_IDLE;
        end
      end
      default: begin
        state_d = MOU_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= MOU_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Store buffer
  // ==========================================================
  // Stores are accepted only after older loads returned,
  // since loads hold the pipeline until their data arrives
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sb_valid_q <= '0;
      head_q     <= '0;
      tail_q     <= '0;
    end else begin
      if (store_acc) begin
        sb_valid_q[tail_q] <= 1'b1;
        tail_q             <= PW'(tail_q + PW'(1));
      end
      if (drain_done) begin
        sb_valid_q[head_q] <= 1'b0;
        head_q             <= PW'(head_q + PW'(1));
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (store_acc) begin
      sb_addr_q[tail_q] <= req_addr;
      sb_data_q[tail_q] <= req_wdata;
    end
  end

  // Drain handshake holds the port once presented
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      drain_busy_q <= 1'b0;
    end else begin
      drain_busy_q <= drain_ok && !mem_gnt;
    end
  end

  // ==========================================================
  // Locked operation operands
  // ==========================================================
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      op_addr_q  <= '0;
      op_wdata_q <= mou_pkg::RST_DATA;
    end else if (swap_acc) begin
      op_addr_q  <= req_addr;
      op_wdata_q <= req_wdata;
    end
  end

  // ==========================================================
  // Response
  // ==========================================================
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= mou_pkg::RST_DATA;
    end else begin
      rsp_valid_q <= 1'b0;
      if (load_fwd) begin
        // Same-address load returns buffered value
        rsp_valid_q <= 1'b1;
        rsp_rdata_q <= fwd_data;
      end else if ((state_q == MOU_LD_WAIT ||
                    state_q == MOU_LK_RWAIT) && mem_rvalid) begin
        rsp_valid_q <= 1'b1;
        rsp_rdata_q <= mem_rdata;
      end
    end
  end

  // Memory system keeps coherence and causal order
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;
  assign sb_empty  = sb_none;

endmodule

//--- shared/mou_pkg.sv
package mou_pkg;

  // ==========================================================
  // Widths and sizes
  // ==========================================================
  localparam int ADDR_W   = 32;
  localparam int DATA_W   = 32;
  localparam int SB_DEPTH = 8;

  // ==========================================================
  // Request kinds from the pipeline
  // ==========================================================
  typedef enum logic [1:0] {
    MOU_OP_LOAD  = 2'h0,
    MOU_OP_STORE = 2'h1,
    MOU_OP_SWAP  = 2'h2
  } mou_op_t;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [DATA_W-1:0] RST_DATA = 32'h00000000;

endpackage

//--- design/mou_sb_match.sv
`timescale 1ns/1ps

module mou_sb_match #(
  parameter int DEPTH = 8,
  parameter int AW    = 32,
  parameter int DW    = 32,
  parameter int PW    = 3
) (
  input  wire logic [DEPTH-1:0]         valid,
  input  wire logic [DEPTH*AW-1:0]      addr_flat,
  input  wire logic [DEPTH*DW-1:0]      data_flat,
  input  wire logic [PW-1:0]            head,
  input  wire logic [AW-1:0]            look_addr,
  output logic                          hit,
  output logic [DW-1:0]                 hit_data
);

  // ==========================================================
  // Youngest matching entry, scanned oldest to youngest
  // ==========================================================
  always_comb begin
    logic [PW-1:0] idx;
    idx      = '0;
    hit      = 1'b0;
    hit_data = '0;
    for (int i = 0; i < DEPTH; i++) begin
      idx = PW'(head + PW'(i));
      if (valid[idx] && addr_flat[idx*AW +: AW] == look_addr) begin
        hit      = 1'b1;
        hit_data = data_flat[idx*DW +: DW];
      end
    end
  end

endmodule

//--- test/mou_core_props.sv
`timescale 1ns/1ps

// ====================
// Ordering checks
module mou_core_props (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [1:0]  req_op,
  input wire logic        rsp_valid,
  input wire logic [31:0] rsp_rdata,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_lock,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_gnt,
  input wire logic        mem_rvalid,
  input wire logic [31:0] mem_rdata,
  input wire logic        sb_empty
);
  logic        rd_q;
  logic [31:0] la_q;
  wire         rd_g = mem_req && mem_gnt && !mem_we;

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) rd_q <= 1'b0;
    else if (rd_g) rd_q <= 1'b1;
    else if (mem_rvalid) rd_q <= 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (rd_g && mem_lock) la_q <= mem_addr;
  end

  a_req_hold: assert property (
    mem_req && !mem_gnt |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before grant");
  a_rsp_ret: assert property (
    mem_rvalid |=> rsp_valid && rsp_rdata == $past(mem_rdata))
    else $error("read return not answered");
  a_lock_wr: assert property (
    rd_g && mem_lock |-> ##[2:8] (mem_req && mem_lock && mem_we
      && mem_addr == la_q))
    else $error("locked write missing");
  a_no_wr_rd: assert property (
    rd_q |-> !(mem_req && mem_we && mem_gnt))
    else $error("write during open read");
  a_lock_empty: assert property (
    mem_req && mem_lock && !mem_we |-> sb_empty)
    else $error("locked read with stores pending");
  a_empty_idle: assert property (
    sb_empty |-> !(mem_req && mem_we && !mem_lock))
    else $error("write with empty buffer");
  a_fwd_next: assert property (
    req_valid && req_ready && req_op == 2'h0 && !mem_gnt |=> rsp_valid)
    else $error("forwarded load not answered");
  a_rsp_cause: assert property (
    rsp_valid |-> $past(mem_rvalid)
      || $past(req_valid && req_ready && req_op == 2'h0))
    else $error("response without cause");
endmodule

bind mou_core mou_core_props u_props (.mclk(mclk), .reset(reset),
  .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
  .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_req(mem_req),
  .mem_we(mem_we), .mem_lock(mem_lock), .mem_addr(mem_addr),
  .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
  .sb_empty(sb_empty));

//--- test/mou_mem_model.sv
`timescale 1ns/1ps

// ====================
// Shared memory stand-in
module mou_mem_model (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_gnt,
  output logic             mem_rvalid,
  output logic [31:0]      mem_rdata
);
  logic [31:0] m [logic [31:0]];
  logic [1:0]  cnt_q;

  // One array serialises all writes and locks
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      mem_gnt <= 1'b0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 32'h0;
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      mem_gnt <= mem_req && !mem_gnt && (!slow || cnt_q == 2'h0);
      mem_rvalid <= mem_req && mem_gnt && !mem_we;
      mem_rdata <= ~mem_rdata;
      if (mem_req && mem_gnt && mem_we) m[mem_addr] = mem_wdata;
      if (mem_req && mem_gnt && !mem_we)
        mem_rdata <= m.exists(mem_addr) ? m[mem_addr]
                                        : mem_addr ^ 32'hA5A5A5A5;
    end
  end
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps

// ====================
// Ordering bench
module tb_top;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        req_valid = 1'b0;
  logic [1:0]  req_op = 2'h0;
  logic [31:0] req_addr = 32'h0;
  logic [31:0] req_wdata = 32'h0;
  logic        slow = 1'b0;
  logic        sl = 1'b0;
  logic        req_ready, rsp_valid, mem_req, mem_we, mem_lock, mem_gnt;
  logic        mem_rvalid, sb_empty;
  logic [31:0] rsp_rdata, mem_addr, mem_wdata, mem_rdata;
  int          bad_count = 0;
  int          check_count = 0;
  int          seed = 32'hE717;
  logic [31:0] exp_m [logic [31:0]];
  logic [31:0] rq [$];
  logic [64:0] wq [$];
  logic [64:0] exp_r;
  logic [64:0] exp_w;

  always #2.5 mclk = ~mclk;

  mou_core dut_u (.mclk(mclk), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_lock(mem_lock),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_gnt(mem_gnt),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .sb_empty(sb_empty));
  mou_mem_model mem_u (.mclk(mclk), .reset(reset), .slow(slow),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata));

  function automatic logic [31:0] peek(input logic [31:0] a);
    return exp_m.exists(a) ? exp_m[a] : a ^ 32'hA5A5A5A5;
  endfunction

  task automatic chk(input logic [64:0] got, input logic [64:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Drives one request and returns at its taking edge
  task automatic op(input logic [1:0] o, input logic [31:0] a, d);
    int n;
    @(negedge mclk);
    n = 0;
    slow = sl;
    req_valid = 1'b1;
    req_op = o;
    req_addr = a;
    req_wdata = d;
    #2;
    while (req_ready !== 1'b1 && n < 400) begin
      @(negedge mclk);
      #2;
      n++;
    end
    if (n >= 400) bad_count++;
    if (o != 2'h1) rq.push_back(peek(a));
    if (o != 2'h0) wq.push_back({o[1], a, d});
    if (o != 2'h0) exp_m[a] = d;
    @(posedge mclk);
  endtask

  task automatic drain;
    int n;
    n = 0;
    @(negedge mclk);
    req_valid = 1'b0;
    while (sb_empty !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 400) bad_count++;
    // Room for a slow locked read and write to finish
    repeat (20) @(negedge mclk);
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(negedge mclk) begin
    if (rsp_valid === 1'b1) begin
      exp_r = rq.size() ? rq.pop_front() : 0;
      chk(rsp_rdata, exp_r);
    end
    if ((mem_req && mem_we && mem_gnt) === 1'b1) begin
      exp_w = wq.size() ? wq.pop_front() : 0;
      chk({mem_lock, mem_addr, mem_wdata}, exp_w);
    end
  end

  initial begin
    #200000;
    bad_count++;
    end_sim;
  end

  initial begin
    int i;
    repeat (10) @(negedge mclk);
    reset = 1'b0;
    chk(sb_empty, 1'b1);
    op(2'h0, 32'h40, 32'h0);
    op(2'h0, 32'h44, 32'h0);
    drain;
    $display("test miss done");
    sl = 1'b1;
    for (i = 1; i < 4; i++) op(2'h1, 32'h80, 32'h11 * i);
    op(2'h0, 32'h80, 32'h0);
    op(2'h0, 32'h84, 32'h0);
    drain;
    $display("test forward done");
    op(2'h1, 32'h90, 32'h5);
    op(2'h2, 32'h90, 32'hAA);
    op(2'h0, 32'h90, 32'h0);
    drain;
    $display("test swap done");
    for (i = 0; i < 10; i++)
      op(2'h1, 32'h100 + i, $random(seed));
    drain;
    chk(wq.size(), 0);
    for (i = 0; i < 10; i++) op(2'h0, 32'h100 + i, 32'h0);
    drain;
    $display("test fill done");
    for (i = 0; i < 60; i++) begin
      sl = $random(seed);
      op(2'($unsigned($random(seed)) % 3), 32'h200 + 4 * (i % 4),
         $random(seed));
    end
    drain;
    chk(rq.size(), 0);
    $display("test random done");
    end_sim;
  end
endmodule
